// file: verilog/prc_router.sv
// packet router core: five-port routing core with four link codecs
module prc_router (
   input  wire logic       clk,
   input  wire logic       nrst,
   prc_link_if.router      lk,
   input  wire logic [4:0] run_div,
   input  wire logic       sys_in_valid,
   input  wire logic [8:0] sys_in_word,
   output logic            sys_in_ready,
   output logic            sys_out_valid,
   output logic [8:0]      sys_out_word,
   input  wire logic       sys_out_ready
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      prc_pkg::prc_rx_s  [3:0]        rx;
      prc_pkg::prc_tx_s  [3:0]        tx;
      logic              [3:0]        run;
      logic              [3:0][4:0]   div;
      logic              [4:0]        sfull;
      logic              [4:0][8:0]   sword;
      prc_pkg::prc_src_e [4:0]        smode;
      logic              [4:0][2:0]   sdst;
      logic              [4:0]        oval;
      logic              [4:0][2:0]   own;
      logic              [4:0][2:0]   rr;
      logic              [255:0][2:0] lut;
      logic                           cbusy;
      logic              [2:0]        csrc;
      logic              [1:0]        cstep;
      logic              [7:0]        cop;
      logic              [7:0]        caddr;
      logic              [7:0]        cdat;
      logic                           rq;
      logic              [2:0]        rdst;
      logic              [1:0]        ridx;
      logic                           so_v;
      logic              [8:0]        so_w;
      logic                           si_rdy;
   } prc_rtr_s;

   prc_rtr_s q_r;
   prc_rtr_s q_nxt;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // requester c has a word pending for output d
   function automatic logic prc_wants(input prc_rtr_s r, input int c,
                                      input int d);
      if (c == prc_pkg::CFG_REQ) begin
         return r.rq && (int'(r.rdst) == d);
      end
      return r.sfull[c] && (r.smode[c] == prc_pkg::PRC_ROUTE) &&
             (int'(r.sdst[c]) == d);
   endfunction : prc_wants

   // config read reply: address, table entry, end marker
   function automatic logic [8:0] prc_reply(input prc_rtr_s r);
      case (r.ridx)
         2'h0:    return {1'b0, r.caddr};
         2'h1:    return {6'h00, r.lut[r.caddr]};
         default: return prc_pkg::EOP_W;
      endcase
   endfunction : prc_reply

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [8:0] w;
      logic [7:0] b;
      logic [2:0] ent;
      logic       av;
      logic       rdy;
      logic       found;
      int         o;
      int         c;
      w     = 9'h000;
      b     = 8'h00;
      ent   = 3'h0;
      av    = 1'b0;
      rdy   = 1'b0;
      found = 1'b0;
      o     = 0;
      c     = 0;
      q_nxt = q_r;

      // link codecs; a one-word holding stage per link stands in for
      // the receive fifo, so a char landing on a full stage is lost
      for (int i = 0; i < prc_pkg::NLINK; i++) begin
         q_nxt.rx[i] = prc_pkg::prc_rx_step(q_r.rx[i], lk.d_up[i],
                                            lk.s_up[i]);
         q_nxt.tx[i] = prc_pkg::prc_tx_step(q_r.tx[i],
            q_r.run[i] ? run_div : q_r.div[i]);
         if (!q_r.run[i]) q_nxt.div[i] = lk.tx_div;
         if (q_r.rx[i].v) begin
            q_nxt.run[i] = 1'b1;
            if (!q_r.sfull[i]) begin
               q_nxt.sfull[i] = 1'b1;
               q_nxt.sword[i] = q_r.rx[i].w;
            end
         end
      end

      // system port in and out
      if (sys_in_valid && q_r.si_rdy) begin
         q_nxt.sfull[prc_pkg::SYS_PORT] = 1'b1;
         q_nxt.sword[prc_pkg::SYS_PORT] = sys_in_word;
      end
      if (q_r.so_v && sys_out_ready) q_nxt.so_v = 1'b0;

      // read logic: header decode, spill and config capture
      for (int s = 0; s < prc_pkg::NSRC; s++) begin
         if (q_r.sfull[s]) begin
            w   = q_r.sword[s];
            b   = w[7:0];
            ent = q_r.lut[b];
            case (q_r.smode[s])
               prc_pkg::PRC_HDR: begin
                  if (w[8]) begin
                     q_nxt.sfull[s] = 1'b0; // stray end marker
                  end else if (b == prc_pkg::HDR_CFG) begin
                     // one transaction at a time; later ones wait
                     if (!q_nxt.cbusy) begin
                        q_nxt.sfull[s] = 1'b0;
                        q_nxt.smode[s] = prc_pkg::PRC_CFG;
                        q_nxt.cbusy    = 1'b1;
                        q_nxt.csrc     = 3'(s);
                        q_nxt.cstep    = 2'h0;
                     end
                  end else if (prc_pkg::prc_is_port(b)) begin
                     q_nxt.sfull[s] = 1'b0; // path byte is stripped
                     q_nxt.sdst[s]  = 3'(b - 8'h01);
                     q_nxt.smode[s] = prc_pkg::PRC_ROUTE;
                  end else if (b >= prc_pkg::LOG_LO &&
                               prc_pkg::prc_is_port({5'h00, ent})) begin
                     q_nxt.sdst[s]  = ent - 3'h1;
                     q_nxt.smode[s] = prc_pkg::PRC_ROUTE;
                  end else begin
                     q_nxt.sfull[s] = 1'b0;
                     q_nxt.smode[s] = prc_pkg::PRC_SPILL;
                  end
               end
               prc_pkg::PRC_SPILL: begin
                  q_nxt.sfull[s] = 1'b0;
                  if (w[8]) q_nxt.smode[s] = prc_pkg::PRC_HDR;
               end
               prc_pkg::PRC_CFG: begin
                  q_nxt.sfull[s] = 1'b0;
                  if (w[8]) begin
                     q_nxt.smode[s] = prc_pkg::PRC_HDR;
                     q_nxt.cbusy    = 1'b0; // short packet: ignored
                     if (q_r.cstep == prc_pkg::CSTEP_FULL) begin
                        if (q_r.cop == prc_pkg::OP_WR) begin
                           q_nxt.lut[q_r.caddr] = q_r.cdat[2:0];
                        end else if (q_r.cop == prc_pkg::OP_RD) begin
                           q_nxt.cbusy = 1'b1;
                           q_nxt.rq    = 1'b1;
                           q_nxt.rdst  = q_r.csrc; // back to the asker
                           q_nxt.ridx  = 2'h0;
                        end
                     end
                  end else begin
                     case (q_r.cstep)
                        2'h0:    q_nxt.cop   = b;
                        2'h1:    q_nxt.caddr = b;
                        2'h2:    q_nxt.cdat  = b;
                        default: q_nxt.cop   = q_r.cop;
                     endcase
                     if (q_r.cstep != prc_pkg::CSTEP_FULL) begin
                        q_nxt.cstep = q_r.cstep + 2'h1;
                     end
                  end
               end
               default: q_nxt.smode[s] = q_r.smode[s];
            endcase
         end
      end

      // write logic: forward for the owner, else arbitrate
      for (int d = 0; d < prc_pkg::NSRC; d++) begin
         if (q_r.oval[d]) begin
            o   = int'(q_r.own[d]);
            av  = prc_wants(q_r, o, d);
            w   = (o == prc_pkg::CFG_REQ) ? prc_reply(q_r) : q_r.sword[o];
            rdy = (d < prc_pkg::NLINK) ? ~q_r.tx[d % prc_pkg::NLINK].busy
                                       : ~q_r.so_v;
            if (av && rdy) begin
               if (d < prc_pkg::NLINK) begin
                  q_nxt.tx[d % prc_pkg::NLINK] = prc_pkg::prc_tx_load(
                     q_nxt.tx[d % prc_pkg::NLINK], w);
               end else begin
                  q_nxt.so_v = 1'b1;
                  q_nxt.so_w = w;
               end
               if (o == prc_pkg::CFG_REQ) begin
                  q_nxt.ridx = q_r.ridx + 2'h1;
                  if (w[8]) begin
                     q_nxt.rq    = 1'b0;
                     q_nxt.cbusy = 1'b0;
                  end
               end else begin
                  q_nxt.sfull[o] = 1'b0;
                  if (w[8]) q_nxt.smode[o] = prc_pkg::PRC_HDR;
               end
               if (w[8]) q_nxt.oval[d] = 1'b0;
            end
         end else begin
            // scan from the slot after the last grant
            found = 1'b0;
            for (int k = 0; k < prc_pkg::NREQ; k++) begin
               c = (int'(q_r.rr[d]) + k) % prc_pkg::NREQ;
               if (!found && prc_wants(q_r, c, d)) begin
                  found         = 1'b1;
                  q_nxt.oval[d] = 1'b1;
                  q_nxt.own[d]  = 3'(c);
                  q_nxt.rr[d]   = 3'((c + 1) % prc_pkg::NREQ);
               end
            end
         end
      end

      q_nxt.si_rdy = ~q_nxt.sfull[prc_pkg::SYS_PORT];
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // tables clear at reset: every logical address starts unconfigured
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs come straight from the state flops
   always_comb begin
      for (int i = 0; i < prc_pkg::NLINK; i++) begin
         lk.d_dn[i] = q_r.tx[i].d;
         lk.s_dn[i] = q_r.tx[i].s;
      end
      sys_in_ready  = q_r.si_rdy;
      sys_out_valid = q_r.so_v;
      sys_out_word  = q_r.so_w;
   end

endmodule : prc_router

// file: verilog/prc_pkg.sv
// packet router core: shared constants, link codec state and helpers
package prc_pkg;

   // ---------------------------------------------------------------
   // sizes and clocking
   // ---------------------------------------------------------------
   localparam int NLINK     = 4;   // serial link ports
   localparam int NSRC      = 5;   // link ports plus the system port
   localparam int NREQ      = 6;   // sources plus the configuration block
   localparam int CFG_REQ   = 5;   // requester index of the config block
   localparam int SYS_PORT  = 4;   // index of the system port
   localparam int CLK_MHZ   = 250; // core and transmit clock
   localparam int INIT_MBPS = 10;  // link initialisation rate
   localparam logic [4:0] INIT_DIV  = 5'(CLK_MHZ / INIT_MBPS);
   localparam logic [3:0] CHAR_BITS = 4'h9;

   // ---------------------------------------------------------------
   // header bytes, end markers and config opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] HDR_CFG = 8'h00;
   localparam logic [7:0] PATH_LO = 8'h01;
   localparam logic [7:0] PATH_HI = 8'h05;
   localparam logic [7:0] LOG_LO  = 8'h20;
   localparam logic [8:0] EOP_W   = 9'h100;
   localparam logic [8:0] EEP_W   = 9'h101;
   localparam logic [7:0] OP_WR   = 8'h01;
   localparam logic [7:0] OP_RD   = 8'h02;
   localparam logic [1:0] CSTEP_FULL = 2'h3;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PRC_HDR, PRC_ROUTE, PRC_SPILL, PRC_CFG
   } prc_src_e;

   typedef struct packed {
      logic       d;
      logic       s;
      logic       busy;
      logic [3:0] nb;
      logic [4:0] cnt;
      logic [8:0] sh;
   } prc_tx_s;

   typedef struct packed {
      logic       d1;
      logic       s1;
      logic       d2;
      logic       s2;
      logic       xp;
      logic       v;
      logic [3:0] nb;
      logic [8:0] sh;
      logic [8:0] w;
   } prc_rx_s;

   // ---------------------------------------------------------------
   // data-strobe codec steps
   // ---------------------------------------------------------------
   // one bit every div clocks; strobe flips when data repeats
   function automatic prc_tx_s prc_tx_step(input prc_tx_s    t,
                                           input logic [4:0] div);
      prc_tx_s n;
      n = t;
      if (t.busy) begin
         if (t.cnt + 5'h1 >= div) begin
            n.cnt  = 5'h0;
            n.d    = t.sh[0];
            if (t.sh[0] == t.d) n.s = ~t.s;
            n.sh   = t.sh >> 1;
            n.nb   = t.nb - 4'h1;
            n.busy = (t.nb != 4'h1);
         end else begin
            n.cnt = t.cnt + 5'h1;
         end
      end
      return n;
   endfunction : prc_tx_step

   function automatic prc_tx_s prc_tx_load(input prc_tx_s    t,
                                           input logic [8:0] w);
      prc_tx_s n;
      n      = t;
      n.sh   = w;
      n.nb   = CHAR_BITS;
      n.cnt  = 5'h0;
      n.busy = 1'b1;
      return n;
   endfunction : prc_tx_load

   // lines pass two flops; a change of data xor strobe marks a bit
   function automatic prc_rx_s prc_rx_step(input prc_rx_s r,
                                           input logic    din,
                                           input logic    sin);
      prc_rx_s n;
      n    = r;
      n.v  = 1'b0;
      n.d1 = din;
      n.s1 = sin;
      n.d2 = r.d1;
      n.s2 = r.s1;
      n.xp = r.d2 ^ r.s2;
      if ((r.d2 ^ r.s2) != r.xp) begin
         n.sh = {r.d2, r.sh[8:1]};
         if (r.nb == CHAR_BITS - 4'h1) begin
            n.w  = n.sh;
            n.v  = 1'b1;
            n.nb = 4'h0;
         end else begin
            n.nb = r.nb + 4'h1;
         end
      end
      return n;
   endfunction : prc_rx_step

   function automatic logic prc_is_port(input logic [7:0] b);
      return (b >= PATH_LO) && (b <= PATH_HI);
   endfunction : prc_is_port

endpackage : prc_pkg

// file: verilog/prc_link_if.sv
// packet router core: data-strobe lines between router and link nodes
interface prc_link_if;
   logic [3:0] d_dn;   // router to node data
   logic [3:0] s_dn;   // router to node strobe
   logic [3:0] d_up;   // node to router data
   logic [3:0] s_up;   // node to router strobe
   logic [4:0] tx_div; // init-rate divisor supplied by the link node

   modport router (input d_up, input s_up, input tx_div,
                   output d_dn, output s_dn);
   modport node   (output d_up, output s_up, output tx_div,
                   input d_dn, input s_dn);
endinterface : prc_link_if

// file: verilog/prc_node.sv
// packet router core: remote link nodes at the far end of the links
module prc_node #(
   parameter logic [4:0] NODE_DIV = prc_pkg::INIT_DIV
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   prc_link_if.node              lk,
   input  wire logic [3:0]       in_valid,
   input  wire logic [3:0][8:0]  in_word,
   output logic      [3:0]       in_ready,
   output logic      [3:0]       out_valid,
   output logic      [3:0][8:0]  out_word
);

   typedef struct packed {
      prc_pkg::prc_rx_s [3:0]      rx;
      prc_pkg::prc_tx_s [3:0]      tx;
      logic             [3:0]      irdy;
      logic             [3:0]      ov;
      logic             [3:0][8:0] ow;
      logic             [4:0]      div;
   } prc_node_s;

   prc_node_s q_r;
   prc_node_s q_nxt;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // node sends one bit every NODE_DIV clocks and drives tx_div with INIT_DIV from the first clock after reset
   always_comb begin
      q_nxt     = q_r;
      q_nxt.div = prc_pkg::INIT_DIV;
      for (int i = 0; i < prc_pkg::NLINK; i++) begin
         q_nxt.rx[i] = prc_pkg::prc_rx_step(q_r.rx[i], lk.d_dn[i],
                                            lk.s_dn[i]);
         q_nxt.tx[i] = prc_pkg::prc_tx_step(q_r.tx[i], NODE_DIV);
         q_nxt.ov[i] = q_r.rx[i].v;
         if (q_r.rx[i].v) q_nxt.ow[i] = q_r.rx[i].w;
         if (in_valid[i] && q_r.irdy[i]) begin
            q_nxt.tx[i] = prc_pkg::prc_tx_load(q_nxt.tx[i], in_word[i]);
         end
         q_nxt.irdy[i] = ~q_nxt.tx[i].busy;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs come straight from the state flops
   always_comb begin
      for (int i = 0; i < prc_pkg::NLINK; i++) begin
         lk.d_up[i] = q_r.tx[i].d;
         lk.s_up[i] = q_r.tx[i].s;
      end
      lk.tx_div = q_r.div;
      in_ready  = q_r.irdy;
      out_valid = q_r.ov;
      out_word  = q_r.ow;
   end

endmodule : prc_node

// file: sim/prc_link_properties.sv
// assertions on the data-strobe lines between router and link nodes
module prc_link_properties (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [3:0] d_dn,
   input wire logic [3:0] s_dn,
   input wire logic [3:0] d_up,
   input wire logic [3:0] s_up,
   input wire logic [4:0] tx_div
);
   // ---------------------------------------------------------------
   // helper state
   // ---------------------------------------------------------------
   logic [3:0]      pd_dn_r, ps_dn_r, pd_up_r, ps_up_r;
   logic [3:0]      seen_up_r; // node has sent a bit on this link
   logic [3:0][4:0] gap_r;     // cycles since last router bit, saturating
   logic [3:0]      dn_chg, up_chg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // a bit boundary is any change of data xor strobe
   assign dn_chg = (d_dn ^ s_dn) ^ (pd_dn_r ^ ps_dn_r);
   assign up_chg = (d_up ^ s_up) ^ (pd_up_r ^ ps_up_r);

   // previous line levels and router bit spacing
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pd_dn_r   <= 4'h0;
         ps_dn_r   <= 4'h0;
         pd_up_r   <= 4'h0;
         ps_up_r   <= 4'h0;
         seen_up_r <= 4'h0;
         gap_r     <= {4{5'h1f}};
      end else begin
         pd_dn_r   <= d_dn;
         ps_dn_r   <= s_dn;
         pd_up_r   <= d_up;
         ps_up_r   <= s_up;
         seen_up_r <= seen_up_r | up_chg;
         for (int i = 0; i < 4; i++) begin
            if (dn_chg[i]) begin
               gap_r[i] <= 5'h00;
            end else if (gap_r[i] != 5'h1f) begin
               gap_r[i] <= gap_r[i] + 5'h01;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   // run divisor of the bench is 3, node divisor 4
   sequence dn_quiet(int k);
      !dn_chg[k] [*2];
   endsequence
   sequence up_quiet(int k);
      !up_chg[k] [*3];
   endsequence

   a_dn_one_flip: assert property (
      ((d_dn ^ pd_dn_r) & (s_dn ^ ps_dn_r)) == 4'h0)
      else $error("router changed data and strobe together");
   a_up_one_flip: assert property (
      ((d_up ^ pd_up_r) & (s_up ^ ps_up_r)) == 4'h0)
      else $error("node changed data and strobe together");
   a_rst_idle: assert property (
      $rose(nrst) |-> (d_dn | s_dn | d_up | s_up) == 4'h0)
      else $error("lines not low out of reset");
   a_div_init: assert property (
      $past(nrst) |-> tx_div == prc_pkg::INIT_DIV)
      else $error("init divisor wrong");

   for (genvar g = 0; g < 4; g++) begin : g_link
      a_init_gap: assert property (
         dn_chg[g] && !seen_up_r[g] |-> gap_r[g] >= 5'h18)
         else $error("router left init rate early");
      a_dn_rate: assert property (dn_chg[g] |=> dn_quiet(g))
         else $error("router bit shorter than divisor");
      a_up_rate: assert property (up_chg[g] |=> up_quiet(g))
         else $error("node bit shorter than divisor");
   end
endmodule : prc_link_properties

// file: sim/tb_prc_router.sv
// self-checking testbench: router and link nodes joined back to back
module tb_prc_router;
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam logic [4:0] RUN_DIV  = 5'h03; // short run rate after init
   localparam logic [4:0] NODE_DIV = 5'h04; // short node bit time
   localparam int         LIMIT    = 4000;  // cycles before a wait gives up
   localparam logic [8:0] EOP      = prc_pkg::EOP_W;
   localparam logic [8:0] EEP      = prc_pkg::EEP_W;

   logic            clk, nrst;
   logic            sys_in_valid, sys_in_ready, sys_out_valid, sys_out_ready;
   logic [8:0]      sys_in_word, sys_out_word;
   logic [3:0]      in_valid, in_ready, out_valid;
   logic [3:0][8:0] in_word, out_word;
   logic [8:0]      exp_q[5][$]; // links 0..3, system port 4
   logic [7:0]      bad_hdr[4] = '{8'h06, 8'h1f, 8'h20, 8'h80};
   logic [31:0]     rng;
   logic [7:0]      a, b;
   int              error_cnt, tests_run, wait_n;

   prc_link_if lk ();

   prc_router prc_router_i (
      .clk          (clk),
      .nrst         (nrst),
      .lk           (lk),
      .run_div      (RUN_DIV),
      .sys_in_valid (sys_in_valid),
      .sys_in_word  (sys_in_word),
      .sys_in_ready (sys_in_ready),
      .sys_out_valid(sys_out_valid),
      .sys_out_word (sys_out_word),
      .sys_out_ready(sys_out_ready)
   );

   prc_node #(.NODE_DIV(NODE_DIV)) prc_node_i (
      .clk      (clk),
      .nrst     (nrst),
      .lk       (lk),
      .in_valid (in_valid),
      .in_word  (in_word),
      .in_ready (in_ready),
      .out_valid(out_valid),
      .out_word (out_word)
   );

   prc_link_properties prc_link_properties_i (
      .clk   (clk),
      .nrst  (nrst),
      .d_dn  (lk.d_dn),
      .s_dn  (lk.s_dn),
      .d_up  (lk.d_up),
      .s_up  (lk.s_up),
      .tx_div(lk.tx_div)
   );

   // one 4 ns clock feeds all ports, above a quarter of any link rate
   initial clk = 1'b0;
   always #2 clk = ~clk;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : rnd

   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test

   task automatic give_up();
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_of_test();
   endtask : give_up

   task automatic note(input int dst, input logic [8:0] w[$]);
      foreach (w[k]) exp_q[dst].push_back(w[k]);
   endtask : note

   // valid stays up across words; a word goes at the edge with ready high
   task automatic sys_pkt(input logic [8:0] w[$]);
      int n;
      foreach (w[k]) begin
         sys_in_word  = w[k];
         sys_in_valid = 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (sys_in_ready !== 1'b1 && n < LIMIT);
         if (n >= LIMIT) give_up();
         @(negedge clk);
      end
      sys_in_valid = 1'b0;
      @(negedge clk);
   endtask : sys_pkt

   // optional pause after the header, so a held stage never overflows
   task automatic node_pkt(input int i, input logic [8:0] w[$],
                           input int gap);
      int n;
      foreach (w[k]) begin
         in_word[i]  = w[k];
         in_valid[i] = 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (in_ready[i] !== 1'b1 && n < LIMIT);
         if (n >= LIMIT) give_up();
         @(negedge clk);
         if (k == 0 && gap > 0) begin
            in_valid[i] = 1'b0;
            repeat (gap) @(negedge clk);
         end
      end
      in_valid[i] = 1'b0;
      @(negedge clk);
   endtask : node_pkt

   task automatic take(input int dst, input logic [8:0] got);
      if (exp_q[dst].size() == 0) check(got, 9'h1ff);
      else check(got, exp_q[dst].pop_front());
   endtask : take

   // watcher: each word that leaves is compared with the oldest note
   always @(posedge clk) begin
      if (nrst === 1'b1 && sys_out_valid === 1'b1 && sys_out_ready === 1'b1)
         take(4, sys_out_word);
      for (int i = 0; i < 4; i++) begin
         if (nrst === 1'b1 && out_valid[i] === 1'b1) begin
            take(i, out_word[i]);
         end
      end
   end

   // random back-pressure on the system output
   always @(negedge clk) sys_out_ready <= nrst && (rnd() & 8'h03) != 8'h00;

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rng = 32'h0001_734f;
      nrst = 1'b0;
      sys_in_valid = 1'b0;
      sys_in_word = 9'h000;
      in_valid = 4'h0;
      in_word = '0;
      error_cnt = 0;
      tests_run = 0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      check({4'h0, lk.tx_div}, {4'h0, prc_pkg::INIT_DIV});
      check({1'b0, lk.d_dn, lk.s_dn}, 9'h000);
      // path addressing to every output, both end markers
      for (int p = 1; p <= 5; p++) begin
         a = rnd();
         note(p - 1, '{{1'b0, a}, (p % 2) ? EOP : EEP});
         sys_pkt('{9'(p), {1'b0, a}, (p % 2) ? EOP : EEP});
      end
      $display("path test done");
      // table writes from system and a link, then logical routing
      sys_pkt('{9'h000, {1'b0, prc_pkg::OP_WR},
               9'h040, 9'h003, EOP});
      node_pkt(3, '{9'h000, {1'b0, prc_pkg::OP_WR},
                    9'h0ff, 9'h005, EOP}, 0);
      a = rnd();
      b = rnd();
      note(2, '{9'h040, {1'b0, a}, EOP});
      sys_pkt('{9'h040, {1'b0, a}, EOP});
      note(4, '{9'h0ff, {1'b0, b}, EOP});
      node_pkt(0, '{9'h0ff, {1'b0, b}, EOP}, 0);
      $display("logical test done");
      // bad headers are dropped; a good packet follows untouched
      foreach (bad_hdr[k]) begin
         sys_pkt('{{1'b0, bad_hdr[k]}, {1'b0, rnd()}, EOP});
      end
      a = rnd();
      note(4, '{{1'b0, a}, EOP});
      sys_pkt('{9'h005, {1'b0, a}, EOP});
      $display("spill test done");
      // table read reply comes back through the system output
      note(4, '{9'h040, 9'h003, EOP});
      sys_pkt('{9'h000, {1'b0, prc_pkg::OP_RD},
               9'h040, 9'h000, EOP});
      $display("read test done");
      // link 3 asks for the system output while link 0 still owns it;
      // its end word lands only after link 0 has let go, so no overflow
      a = rnd();
      b = rnd();
      note(4, '{{1'b0, a}, EOP, {1'b0, b}, EOP});
      fork
         node_pkt(0, '{9'h005, {1'b0, a}, EOP}, 0);
         node_pkt(3, '{9'h005, {1'b0, b}, EOP}, 60);
      join
      $display("arbitration test done");
      // link 0 has received, so its transmitter runs at the run rate
      a = rnd();
      note(0, '{{1'b0, a}, EOP});
      sys_pkt('{9'h001, {1'b0, a}, EOP});
      wait_n = 0;
      while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() +
             exp_q[3].size() + exp_q[4].size() != 0 && wait_n < LIMIT) begin
         @(negedge clk);
         wait_n++;
      end
      if (wait_n >= LIMIT) give_up();
      $display("run rate test done");
      end_of_test();
   end
endmodule : tb_prc_router
